// ===== event_flags_cfg.svh
// Constants of the channel event-flag register bank: command codes, field
// positions, reset values and timing counts. Assumes a 20 MHz ref_clk.
`ifndef EVENT_FLAGS_CFG_SVH
`define EVENT_FLAGS_CFG_SVH
`define EVF_CMD_POWER_PEEK   8'h02
`define EVF_CMD_POWER_CLEAR  8'h03
`define EVF_CMD_DISC_PEEK    8'h04
`define EVF_CMD_DISC_CLEAR   8'h05
`define EVF_CMD_FAULT_PEEK   8'h06
`define EVF_CMD_FAULT_CLEAR  8'h07
`define EVF_HI_LSB           4
`define EVF_LO_LSB           0
`define EVF_RESET_VAL        8'h00
`define EVF_CLK_HZ           20000000
`define EVF_MERGE_WAIT_US    5000
`define EVF_MERGE_CYCLES     ((`EVF_MERGE_WAIT_US * (`EVF_CLK_HZ / 1000000)))
`endif

// ===== event_flags_pkg.sv
// Types shared by the event-flag bank: the discovery operating mode.
// Assumes the cfg header supplies all numeric constants.
`default_nettype none
package event_flags_pkg;
    typedef enum logic [1:0] {
        MODE_MANUAL,
        MODE_SEMI_AUTO,
        MODE_AUTO
    } op_mode_e;
endpackage : event_flags_pkg
`default_nettype wire

// ===== pse_port_event_flags.sv
// Power, discovery and fault event-flag registers of four channels (two
// four-pair ports: channels 0/1 and 2/3). Events arrive as one-cycle pulses
// from same-clock state machines; the host reads through a plain command port.
//
// Decided for this implementation: the strobed register port.
`include "event_flags_cfg.svh"
`default_nettype none

module pse_port_event_flags #(
    parameter int unsigned NCH        = 4,
    parameter int unsigned MERGE_WAIT = `EVF_MERGE_CYCLES
) (
    input  wire logic                           ref_clk,
    input  wire logic                           srst,
    input  wire logic                           clk_en,
    input  wire logic [7:0]                     cmd_addr,
    input  wire logic                           cmd_rd,
    input  wire logic                           cmd_wr,
    input  wire logic [7:0]                     cmd_wdata,
    output logic      [7:0]                     cmd_rdata,
    input  wire logic [1:0]                     four_pair,
    input  wire logic [1:0]                     dual_sig,
    input  wire logic [1:0]                     power_on_request,
    input  wire event_flags_pkg::op_mode_e      op_mode,
    input  wire logic                           class_change_only,
    input  wire logic                           detect_change_only,
    input  wire logic [3:0]                     power_good,
    input  wire logic [3:0]                     power_enable,
    input  wire logic [3:0]                     detect_done,
    input  wire logic [3:0]                     detect_changed,
    input  wire logic [3:0]                     class_done,
    input  wire logic [3:0]                     class_changed,
    input  wire logic [3:0]                     unplug_event,
    input  wire logic [3:0]                     overload_timeout,
    input  wire logic [3:0]                     channel_off,
    output logic      [3:0]                     summary_q,
    output logic                                int_n_q
);
    // ---------------------------------------------------------------
    // Checks and helpers
    // ---------------------------------------------------------------
    // Refused at elaboration: the pairing logic is written for two ports
    if (NCH != 4) begin : g_bad_nch
        $error("pse_port_event_flags serves exactly four channels");
    end
    if (MERGE_WAIT < 1) begin : g_bad_wait
        $error("MERGE_WAIT must be at least one cycle");
    end

    // Pair mask of a port: both channels of port p
    function automatic logic [3:0] pair_bits(input logic [3:0] v, input int p);
        logic [3:0] r;
        r = 4'h0;
        r[2*p]   = v[2*p];
        r[2*p+1] = v[2*p+1];
        return r;
    endfunction : pair_bits

    logic [7:0] power_q;
    logic [7:0] disc_q;
    logic [7:0] fault_q;
    logic [3:0] good_prev_q;
    logic [3:0] enable_prev_q;
    logic [3:0] good_seen_q;
    logic [3:0] good_any;
    logic [3:0] det_ready_q;
    logic [3:0] cls_ready_q;
    logic [1:0] merge_arm_q;
    logic [1:0] merge_fire;
    logic [$clog2(MERGE_WAIT+1)-1:0] merge_cnt_q [2];
    logic [3:0] good_set;
    logic [3:0] enable_set;
    logic [3:0] det_set;
    logic [3:0] cls_set;
    logic [3:0] unplug_set;
    logic [3:0] det_evt;
    logic [3:0] cls_evt;
    logic       clr_power;
    logic       clr_disc;
    logic       clr_fault;

    // ---------------------------------------------------------------
    // Event qualification
    // ---------------------------------------------------------------
    // Raw events; the change-only settings narrow what counts
    assign det_evt = detect_change_only ? (detect_done & detect_changed) : detect_done;
    assign cls_evt = class_change_only ? (class_done & class_changed) : class_done;

    // Good changes seen so far plus this cycle's, per channel
    assign good_any = good_seen_q | (power_good ^ good_prev_q);

    // Four-pair pairing: single-signature ports merge, dual-signature split
    always_comb begin
        enable_set = power_enable ^ enable_prev_q;
        good_set   = 4'h0;
        det_set    = 4'h0;
        cls_set    = 4'h0;
        unplug_set = unplug_event;
        for (int p = 0; p < 2; p++) begin
            if (four_pair[p] && !dual_sig[p]) begin
                // Both channels must have changed before either flag shows
                if (&good_any[2*p +: 2])
                    good_set |= pair_bits(4'hF, p);
                if (|pair_bits(unplug_event, p))
                    unplug_set |= pair_bits(4'hF, p);
                // Class flag only on the pair set that was classified
                cls_set |= pair_bits(cls_evt, p) & ((power_on_request[p]) ?
                           pair_bits(4'hF, p) : 4'h0);
            end else begin
                good_set |= pair_bits(power_good ^ good_prev_q, p);
            end
            if (four_pair[p] && !power_on_request[p] &&
                !(dual_sig[p] && op_mode == event_flags_pkg::MODE_AUTO)) begin
                // Deferred: set when both channels are ready or the merge wait runs out
                if (merge_fire[p]) begin
                    det_set |= pair_bits(det_ready_q, p);
                    if (!(dual_sig[p] && op_mode == event_flags_pkg::MODE_MANUAL))
                        cls_set |= pair_bits(cls_ready_q, p);
                end
                if (dual_sig[p] && op_mode == event_flags_pkg::MODE_MANUAL)
                    cls_set |= pair_bits(cls_evt, p);
            end else begin
                det_set |= pair_bits(det_evt, p);
                if (!(four_pair[p] && !dual_sig[p]))
                    cls_set |= pair_bits(cls_evt, p);
            end
        end
    end

    // Previous status levels for change detection
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            good_prev_q   <= 4'h0;
            enable_prev_q <= 4'h0;
        end else if (clk_en) begin
            good_prev_q   <= power_good;
            enable_prev_q <= power_enable;
        end
    end

    // Single-signature good-change collector, emptied once the pair fires
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            good_seen_q <= 4'h0;
        end else if (clk_en) begin
            good_seen_q <= (good_seen_q | (power_good ^ good_prev_q)) & ~good_set;
        end
    end

    // ---------------------------------------------------------------
    // Discovery merge: wait for both channels, then fire within 5 ms
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            det_ready_q <= 4'h0;
            cls_ready_q <= 4'h0;
        end else if (clk_en) begin
            det_ready_q <= (det_ready_q | det_evt) & ~channel_off
                           & ~{{2{merge_fire[1]}}, {2{merge_fire[0]}}};
            cls_ready_q <= (cls_ready_q | cls_evt) & ~channel_off
                           & ~{{2{merge_fire[1]}}, {2{merge_fire[0]}}};
        end
    end

    // Fire when both detect results are in; a timer bounds the wait to 5 ms
    // in case only one channel ever reports.
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            merge_fire[p] = (&det_ready_q[2*p +: 2]) ||
                            (merge_arm_q[p] && merge_cnt_q[p] == '0);
        end
    end

    // One process for both ports' timers keeps each register single-driven
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            merge_arm_q    <= 2'b00;
            merge_cnt_q[0] <= '0;
            merge_cnt_q[1] <= '0;
        end else if (clk_en) begin
            for (int p = 0; p < 2; p++) begin
                if (merge_fire[p]) begin
                    merge_arm_q[p] <= 1'b0;
                end else if (!merge_arm_q[p] && |det_ready_q[2*p +: 2]) begin
                    merge_arm_q[p] <= 1'b1;
                    merge_cnt_q[p] <= ($clog2(MERGE_WAIT+1))'(MERGE_WAIT - 1);
                end else if (merge_arm_q[p]) begin
                    merge_cnt_q[p] <= merge_cnt_q[p] - 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Event registers
    // ---------------------------------------------------------------
    assign clr_power = cmd_rd && cmd_addr == `EVF_CMD_POWER_CLEAR;
    assign clr_disc  = cmd_rd && cmd_addr == `EVF_CMD_DISC_CLEAR;
    assign clr_fault = cmd_rd && cmd_addr == `EVF_CMD_FAULT_CLEAR;

    // Power register: new events win over a same-cycle clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            power_q <= `EVF_RESET_VAL;
        end else if (clk_en) begin
            power_q <= (clr_power ? 8'h00 : power_q) | {good_set, enable_set};
        end
    end

    // Discovery register: off channels drop their bits
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            disc_q <= `EVF_RESET_VAL;
        end else if (clk_en) begin
            disc_q <= ((clr_disc ? 8'h00 : disc_q) & ~{channel_off, channel_off})
                      | {cls_set, det_set};
        end
    end

    // Fault register; overload flags set regardless of shutdown policy and
    // clearing them never reaches the timers, which live outside this block
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fault_q <= `EVF_RESET_VAL;
        end else if (clk_en) begin
            fault_q <= ((clr_fault ? 8'h00 : fault_q) & ~{channel_off, channel_off})
                       | {unplug_set, overload_timeout};
        end
    end

    // ---------------------------------------------------------------
    // Read port, summary and interrupt
    // ---------------------------------------------------------------
    // Both codes of a pair return the same data, the value before any clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cmd_rdata <= 8'h00;
        end else if (clk_en && cmd_rd) begin
            case (cmd_addr)
                `EVF_CMD_POWER_PEEK, `EVF_CMD_POWER_CLEAR: cmd_rdata <= power_q;
                `EVF_CMD_DISC_PEEK,  `EVF_CMD_DISC_CLEAR:  cmd_rdata <= disc_q;
                `EVF_CMD_FAULT_PEEK, `EVF_CMD_FAULT_CLEAR: cmd_rdata <= fault_q;
                default:                                   cmd_rdata <= 8'h00;
            endcase
        end
    end

    // Summary bits: enable, good, discovery, fault kinds; interrupt low while any
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            summary_q <= 4'h0;
            int_n_q   <= 1'b1;
        end else if (clk_en) begin
            summary_q <= {|fault_q, |disc_q, |power_q[7:4], |power_q[3:0]};
            int_n_q   <= ~(|{fault_q, disc_q, power_q});
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_clear_wins_late: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && clr_power && !(|{good_set, enable_set}) |=> power_q == 8'h00)
        else $error("power flags not cleared by clear-on-read");
    a_enable_flag_set: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && power_enable != enable_prev_q |=>
        (power_q[3:0] & $past(power_enable ^ enable_prev_q)) == $past(power_enable ^ enable_prev_q))
        else $error("enable change flag missing");
    a_off_clears_disc: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && channel_off[0] && !cls_set[0] && !det_set[0] |=> !disc_q[0] && !disc_q[4])
        else $error("off channel kept discovery bits");
    a_overload_sets: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && overload_timeout[1] |=> fault_q[1])
        else $error("overload flag missing");
    a_int_release: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && fault_q == 0 && disc_q == 0 && power_q == 0 |=> int_n_q)
        else $error("interrupt held with no flags");
    a_peek_keeps: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && cmd_rd && cmd_addr == `EVF_CMD_POWER_PEEK |=>
        cmd_rdata == $past(power_q) && (power_q & $past(power_q)) == $past(power_q))
        else $error("peek read altered power flags");
    a_summary_or: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en |=> summary_q[3] == |$past(fault_q))
        else $error("summary fault bit wrong");
    a_detect_merge: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && merge_arm_q[0] |-> merge_cnt_q[0] < MERGE_WAIT)
        else $error("merge wait exceeds 5 ms");

    // Read port: the peek codes return the register as it stood
    a_peek_disc_data: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && cmd_rd && cmd_addr == `EVF_CMD_DISC_PEEK |=> cmd_rdata == $past(disc_q))
        else $error("discovery peek data wrong");
    a_peek_fault_data: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && cmd_rd && cmd_addr == `EVF_CMD_FAULT_PEEK |=> cmd_rdata == $past(fault_q))
        else $error("fault peek data wrong");

    // Clearing reads empty the register unless a new event lands with them
    a_clear_disc_done: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && clr_disc && !(|{cls_set, det_set}) |=> disc_q == 8'h00)
        else $error("discovery flags not cleared");
    a_clear_fault_done: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && clr_fault && !(|{unplug_set, overload_timeout}) |=> fault_q == 8'h00)
        else $error("fault flags not cleared");
    a_event_beats_clear: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && clr_fault && overload_timeout[0] |=> fault_q[0])
        else $error("event lost under clearing read");

    // Setting of individual flags
    a_good_flag_set: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && good_set[0] |=> power_q[4])
        else $error("good change flag missing");
    a_unplug_flag_set: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && unplug_set[2] |=> fault_q[6])
        else $error("unplug flag missing");
    a_class_every_cycle: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && !class_change_only && !four_pair[1] && class_done[3]
        |=> disc_q[7])
        else $error("class cycle flag missing");
    a_detect_change_gate: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && detect_change_only && !four_pair[1] && detect_done[2] &&
        !detect_changed[2] |-> !det_set[2])
        else $error("unchanged detect result flagged");

    // Four-pair pairing: single signature merges, dual signature splits.
    // These watch port 0 only; port 1 runs the same loop body, so a fault
    // in the pairing code would show on both ports alike.
    a_single_unplug_both: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && four_pair[0] && !dual_sig[0] && unplug_event[0]
        |=> fault_q[5:4] == 2'b11)
        else $error("single signature unplug not on both channels");
    a_single_good_pair: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && four_pair[0] && !dual_sig[0] |-> good_set[0] == good_set[1])
        else $error("single signature good flags split");
    a_dual_good_each: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && four_pair[0] && dual_sig[0] && power_good[0] != good_prev_q[0]
        |=> power_q[4])
        else $error("dual signature good flag missing");
    a_merge_only_fire: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && four_pair[0] && !dual_sig[0] && !power_on_request[0] &&
        det_set[1:0] != 2'b00 |-> merge_fire[0])
        else $error("deferred detect flag set early");
    a_auto_dual_direct: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && four_pair[0] && dual_sig[0] && op_mode == event_flags_pkg::MODE_AUTO &&
        detect_done[0] && !detect_change_only |=> disc_q[0])
        else $error("auto dual detect flag deferred");

    // Summary and interrupt follow the registers one cycle later
    a_summary_good: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en |=> summary_q[1] == |$past(power_q[7:4]))
        else $error("summary good bit wrong");
    a_int_asserted: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && |{fault_q, disc_q, power_q} |=> !int_n_q)
        else $error("interrupt idle with flags set");
endmodule : pse_port_event_flags
`default_nettype wire

// ===== host_cmd_model.sv
// Host-side model of the command port: issues single-cycle read strobes.
// Assumes the device answers one cycle after the strobe and never stalls.
`default_nettype none
module host_cmd_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] cmd_rdata,
    output var logic  [7:0] cmd_addr,
    output var logic        cmd_rd,
    output var logic        cmd_wr,
    output var logic  [7:0] cmd_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle values; no writable registers sit behind this port
    initial begin
        cmd_addr  = 8'hFF;
        cmd_rd    = 1'b0;
        cmd_wr    = 1'b0;
        cmd_wdata = 8'h00;
    end

    // ----------------------------------------------------------------
    // One read: strobe for a cycle, take data in the following cycle
    // ----------------------------------------------------------------
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        cmd_addr <= a;
        cmd_rd   <= 1'b1;
        @(posedge ref_clk);
        cmd_rd   <= 1'b0;
        cmd_addr <= ~a; // Stale address never looks like a live request
        @(posedge ref_clk);
        d = cmd_rdata; // Launched an edge earlier; no strobe reloads it here
    endtask : rd
endmodule : host_cmd_model
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the channel event-flag bank.
// Assumes a 20 MHz clock and a shortened four-pair merge wait.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                       ref_clk = 1'b0;
    logic                       srst = 1'b1;
    logic [7:0]                 cmd_addr, cmd_wdata, cmd_rdata, d;
    logic                       cmd_rd, cmd_wr;
    logic [1:0]                 four_pair = 2'b00;
    logic [1:0]                 dual_sig = 2'b00;
    logic                       class_change_only = 1'b0;
    logic                       detect_change_only = 1'b0;
    logic [3:0]                 power_good = 4'h0;
    logic [3:0]                 power_enable = 4'h0;
    logic [3:0]                 detect_done = 4'h0, detect_changed = 4'h0;
    logic [3:0]                 class_done = 4'h0, class_changed = 4'h0;
    logic [3:0]                 unplug_event = 4'h0, overload_timeout = 4'h0;
    logic [3:0]                 channel_off = 4'h0, summary_q;
    logic                       int_n_q;
    logic                       clk_en = 1'b1;
    logic [1:0]                 power_on_request = 2'b00;
    event_flags_pkg::op_mode_e  op_mode = event_flags_pkg::MODE_MANUAL;
    int                         miscompares = 0;
    int                         total_checks = 0;

    // 50 ns period
    always #25 ref_clk = ~ref_clk;

    host_cmd_model host_cmd_model_inst (.ref_clk(ref_clk), .cmd_rdata(cmd_rdata),
        .cmd_addr(cmd_addr), .cmd_rd(cmd_rd), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata));

    // Merge wait shortened so the deferred discovery path runs quickly
    pse_port_event_flags #(.NCH(4), .MERGE_WAIT(40)) pse_port_event_flags_inst (
        .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .cmd_addr(cmd_addr),
        .cmd_rd(cmd_rd), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .four_pair(four_pair), .dual_sig(dual_sig), .power_on_request(power_on_request),
        .op_mode(op_mode), .class_change_only(class_change_only),
        .detect_change_only(detect_change_only), .power_good(power_good),
        .power_enable(power_enable), .detect_done(detect_done),
        .detect_changed(detect_changed), .class_done(class_done),
        .class_changed(class_changed), .unplug_event(unplug_event),
        .overload_timeout(overload_timeout), .channel_off(channel_off),
        .summary_q(summary_q), .int_n_q(int_n_q));

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host_cmd_model_inst.rd(a, v);
        check(v, exp);
    endtask : rdchk

    // One-cycle event pulses, then time for flags and summary to settle
    task automatic pulse(input logic [3:0] dd, dc, cd, cc, un, ov, off);
        @(posedge ref_clk);
        {detect_done, detect_changed, class_done, class_changed} <= {dd, dc, cd, cc};
        {unplug_event, overload_timeout, channel_off} <= {un, ov, off};
        @(posedge ref_clk);
        {detect_done, detect_changed, class_done, class_changed} <= 16'h0000;
        {unplug_event, overload_timeout, channel_off} <= 12'h000;
        repeat (3) @(posedge ref_clk);
    endtask : pulse

    // Toggle status levels; each toggle is one change event
    task automatic lev(input logic [3:0] g, input logic [3:0] e);
        @(posedge ref_clk);
        power_good   <= power_good ^ g;
        power_enable <= power_enable ^ e;
        repeat (4) @(posedge ref_clk);
    endtask : lev

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic s_reset();
        for (int a = 2; a <= 9; a++) begin
            rdchk(8'(a), 8'h00);
        end
        check({7'h00, int_n_q}, 8'h01);
        check({4'h0, summary_q}, 8'h00);
    endtask : s_reset

    task automatic s_power();
        lev(4'h4, 4'h1);
        rdchk(8'h02, 8'h41);
        check({7'h00, int_n_q}, 8'h00);
        check({4'h0, summary_q}, 8'h03);
        rdchk(8'h03, 8'h41);
        repeat (2) @(posedge ref_clk);
        check({7'h00, int_n_q}, 8'h01);
        rdchk(8'h02, 8'h00);
    endtask : s_power

    task automatic s_fault();
        pulse(4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h8, 4'h0);
        check({4'h0, summary_q}, 8'h08);
        rdchk(8'h06, 8'h28);
        rdchk(8'h07, 8'h28);
        rdchk(8'h06, 8'h00);
        pulse(4'h1, 4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h0);
        rdchk(8'h06, 8'h12);
        pulse(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1);
        rdchk(8'h06, 8'h02);
        rdchk(8'h04, 8'h00);
        rdchk(8'h07, 8'h02);
    endtask : s_fault

    task automatic s_disc();
        pulse(4'h4, 4'h0, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0);
        check({4'h0, summary_q}, 8'h04);
        rdchk(8'h04, 8'h84);
        rdchk(8'h05, 8'h84);
        @(posedge ref_clk);
        {class_change_only, detect_change_only} <= 2'b11;
        pulse(4'h4, 4'h0, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0);
        rdchk(8'h04, 8'h00);
        pulse(4'h4, 4'h4, 4'h8, 4'h8, 4'h0, 4'h0, 4'h0);
        rdchk(8'h05, 8'h84);
        {class_change_only, detect_change_only} <= 2'b00;
    endtask : s_disc

    // Port 0 wired four-pair: single then dual signature
    task automatic s_four_pair();
        @(posedge ref_clk);
        four_pair <= 2'b01;
        lev(4'h1, 4'h0);
        rdchk(8'h02, 8'h00);
        lev(4'h2, 4'h0);
        rdchk(8'h03, 8'h30);
        lev(4'h0, 4'h2);
        rdchk(8'h03, 8'h02);
        pulse(4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0);
        rdchk(8'h07, 8'h30);
        pulse(4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        rdchk(8'h04, 8'h00);
        pulse(4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        rdchk(8'h05, 8'h03);
        dual_sig <= 2'b01;
        lev(4'h1, 4'h0);
        rdchk(8'h03, 8'h10);
        pulse(4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0);
        rdchk(8'h07, 8'h10);
        {four_pair, dual_sig} <= 4'h0;
    endtask : s_four_pair

    // Overload arrives in the very cycle of a clearing read
    task automatic s_coincide();
        pulse(4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h0, 4'h0);
        fork
            host_cmd_model_inst.rd(8'h07, d);
            begin
                @(posedge ref_clk);
                overload_timeout <= 4'h1;
                @(posedge ref_clk);
                overload_timeout <= 4'h0;
            end
        join
        check(d, 8'h40);
        rdchk(8'h06, 8'h01);
    endtask : s_coincide

    // Port 0 four-pair: merge timeout, signature modes, power-on, freeze
    task automatic s_modes();
        @(posedge ref_clk);
        four_pair <= 2'b01;
        pulse(4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        rdchk(8'h04, 8'h00);
        repeat (45) @(posedge ref_clk);
        rdchk(8'h05, 8'h01);
        dual_sig <= 2'b01;
        pulse(4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0);
        rdchk(8'h05, 8'h20);
        op_mode <= event_flags_pkg::MODE_AUTO;
        pulse(4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        rdchk(8'h05, 8'h01);
        {dual_sig, power_on_request} <= 4'h1;
        op_mode <= event_flags_pkg::MODE_MANUAL;
        pulse(4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0);
        rdchk(8'h05, 8'h10);
        clk_en <= 1'b0;
        pulse(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h0);
        clk_en <= 1'b1;
        rdchk(8'h06, 8'h01);
        {four_pair, power_on_request} <= 4'h0;
    endtask : s_modes

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        s_reset();
        s_power();
        s_fault();
        s_disc();
        s_four_pair();
        s_coincide();
        s_modes();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
